// [hdl/oem_defs.vh]
// register offsets, field positions, reset values and mode codes of the output stage bank
`ifndef OEM_DEFS_VH
`define OEM_DEFS_VH
`define OEM_ADDR_HP_EN 8'hb1
`define OEM_ADDR_UPPER_MODE 8'hb2
`define OEM_ADDR_LOWER_MODE 8'hb3
`define OEM_ADDR_UPPER_SEL 8'hb4
`define OEM_RST_VAL 8'h00
`define OEM_HP_EN_MASK 8'h0f
`define OEM_MODE_MASK 8'h77
`define OEM_SEL_MASK 8'h0f
`define OEM_PAIR_LO_MSB 2
`define OEM_PAIR_LO_LSB 0
`define OEM_PAIR_HI_MSB 6
`define OEM_PAIR_HI_LSB 4
`define OEM_SEL4_MSB 1
`define OEM_SEL4_LSB 0
`define OEM_SEL5_MSB 3
`define OEM_SEL5_LSB 2
`define OEM_MODE_OFF 3'h0
`define OEM_MODE_EVEN 3'h1
`define OEM_MODE_ODD 3'h2
`define OEM_MODE_BOTH 3'h3
`define OEM_MODE_COMP 3'h4
`define OEM_MODE_HCSL 3'h5
`define OEM_MODE_PECL 3'h6
`define OEM_MODE_UNDEF 3'h7
`define OEM_SEL_CODE0 2'h0
`define OEM_SEL_CODE1 2'h1
`endif

// [hdl/oem_pair.v]
// one configurable output pair: mode decode, enables and driven levels
`timescale 1ns/1ps
`default_nettype none
`include "oem_defs.vh"
module oem_pair (
  // control
  input wire [2:0] mode,
  // source clocks already selected for each output
  input wire even_src,
  input wire odd_src,
  // pad side
  output reg even_val,
  output reg odd_val,
  output reg even_oe,
  output reg odd_oe,
  output reg diff_hcsl,
  output reg diff_pecl
);
  always @* begin
    even_val = even_src;
    odd_val = odd_src;
    even_oe = 1'b0;
    odd_oe = 1'b0;
    diff_hcsl = 1'b0;
    diff_pecl = 1'b0;
    case (mode)
      `OEM_MODE_OFF: begin
        even_oe = 1'b0;
        odd_oe = 1'b0;
      end
      `OEM_MODE_EVEN: begin
        even_oe = 1'b1;
      end
      `OEM_MODE_ODD: begin
        odd_oe = 1'b1;
      end
      `OEM_MODE_BOTH: begin
        even_oe = 1'b1;
        odd_oe = 1'b1;
      end
      `OEM_MODE_COMP: begin
        even_oe = 1'b1;
        odd_oe = 1'b1;
        odd_val = ~even_src;
      end
      `OEM_MODE_HCSL: begin
        even_oe = 1'b1;
        odd_oe = 1'b1;
        diff_hcsl = 1'b1;
        odd_val = ~even_src;
      end
      `OEM_MODE_PECL: begin
        even_oe = 1'b1;
        odd_oe = 1'b1;
        diff_pecl = 1'b1;
        odd_val = ~even_src;
      end
      default: begin
        even_oe = 1'b0;
        odd_oe = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// [hdl/oem_regs.v]
// output enable, mode and source select register bank with registered pad controls
`timescale 1ns/1ps
`default_nettype none
`include "oem_defs.vh"
module oem_regs (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // host configuration port
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  input wire cfg_wr,
  input wire cfg_rd,
  output reg [7:0] cfg_rdata_q,
  // high performance single ended outputs
  input wire [3:0] hp_src,
  output reg [3:0] hp_single_ended_out_q,
  output reg [3:0] hp_single_ended_enable_bits_q,
  // source taps for outputs four and five
  input wire synth_three_divider_a,
  input wire synth_one_divider_c,
  input wire synth_three_divider_c,
  input wire synth_one_divider_d,
  // sources for the other configurable outputs
  input wire [3:0] low_src,
  input wire [1:0] six_seven_src,
  // configurable outputs, index 0 is cfg_clock_out_zero
  output reg [7:0] cfg_clock_out_q,
  output reg [7:0] cfg_clock_oe_q,
  output reg [3:0] pair_hcsl_q,
  output reg [3:0] pair_pecl_q
);
  reg [7:0] hp_en_q;
  reg [7:0] upper_mode_q;
  reg [7:0] lower_mode_q;
  reg [7:0] upper_sel_q;
  reg [7:0] rdata_d;
  reg out_four_src;
  reg out_five_src;
  // source levels come from other clock domains: two flops before any logic
  reg [13:0] pin_meta_q;
  reg [13:0] pin_sync_q;
  wire [13:0] pin_raw;
  wire [11:0] mode_all;
  wire [7:0] src_all;
  wire [7:0] val_all;
  wire [7:0] oe_all;
  wire [3:0] hcsl_all;
  wire [3:0] pecl_all;

  assign pin_raw = {hp_src, low_src, six_seven_src, synth_three_divider_a,
                    synth_one_divider_c, synth_three_divider_c, synth_one_divider_d};

  // only the second stage is read by the logic below
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_q <= 14'h0000;
      pin_sync_q <= 14'h0000;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // writable bits only; reserved positions stay zero
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hp_en_q <= `OEM_RST_VAL;
      upper_mode_q <= `OEM_RST_VAL;
      lower_mode_q <= `OEM_RST_VAL;
      upper_sel_q <= `OEM_RST_VAL;
    end else if (cfg_wr) begin
      case (cfg_addr)
        `OEM_ADDR_HP_EN: hp_en_q <= cfg_wdata & `OEM_HP_EN_MASK;
        `OEM_ADDR_UPPER_MODE: upper_mode_q <= cfg_wdata & `OEM_MODE_MASK;
        `OEM_ADDR_LOWER_MODE: lower_mode_q <= cfg_wdata & `OEM_MODE_MASK;
        `OEM_ADDR_UPPER_SEL: upper_sel_q <= cfg_wdata & `OEM_SEL_MASK;
        default: begin
        end
      endcase
    end
  end

  always @* begin
    rdata_d = 8'h00;
    if (cfg_rd) begin
      case (cfg_addr)
        `OEM_ADDR_HP_EN: rdata_d = hp_en_q;
        `OEM_ADDR_UPPER_MODE: rdata_d = upper_mode_q;
        `OEM_ADDR_LOWER_MODE: rdata_d = lower_mode_q;
        `OEM_ADDR_UPPER_SEL: rdata_d = upper_sel_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // source muxes; reserved codes drive a quiet low
  always @* begin
    case (upper_sel_q[`OEM_SEL4_MSB:`OEM_SEL4_LSB])
      `OEM_SEL_CODE0: out_four_src = pin_sync_q[3];
      `OEM_SEL_CODE1: out_four_src = pin_sync_q[2];
      default: out_four_src = 1'b0;
    endcase
    case (upper_sel_q[`OEM_SEL5_MSB:`OEM_SEL5_LSB])
      `OEM_SEL_CODE0: out_five_src = pin_sync_q[1];
      `OEM_SEL_CODE1: out_five_src = pin_sync_q[0];
      default: out_five_src = 1'b0;
    endcase
  end

  assign src_all = {pin_sync_q[5:4], out_five_src, out_four_src, pin_sync_q[9:6]};
  assign mode_all = {upper_mode_q[`OEM_PAIR_HI_MSB:`OEM_PAIR_HI_LSB],
                     upper_mode_q[`OEM_PAIR_LO_MSB:`OEM_PAIR_LO_LSB],
                     lower_mode_q[`OEM_PAIR_HI_MSB:`OEM_PAIR_HI_LSB],
                     lower_mode_q[`OEM_PAIR_LO_MSB:`OEM_PAIR_LO_LSB]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pair
      oem_pair u_pair (
        .mode(mode_all[3*gi+2:3*gi]),
        .even_src(src_all[2*gi]),
        .odd_src(src_all[2*gi+1]),
        .even_val(val_all[2*gi]),
        .odd_val(val_all[2*gi+1]),
        .even_oe(oe_all[2*gi]),
        .odd_oe(oe_all[2*gi+1]),
        .diff_hcsl(hcsl_all[gi]),
        .diff_pecl(pecl_all[gi])
      );
    end
  endgenerate

  // all pad controls registered
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata_q <= 8'h00;
      hp_single_ended_out_q <= 4'h0;
      hp_single_ended_enable_bits_q <= 4'h0;
      cfg_clock_out_q <= 8'h00;
      cfg_clock_oe_q <= 8'h00;
      pair_hcsl_q <= 4'h0;
      pair_pecl_q <= 4'h0;
    end else begin
      cfg_rdata_q <= rdata_d;
      hp_single_ended_enable_bits_q <= hp_en_q[3:0];
      hp_single_ended_out_q <= pin_sync_q[13:10] & hp_en_q[3:0];
      cfg_clock_out_q <= val_all & oe_all;
      cfg_clock_oe_q <= oe_all;
      pair_hcsl_q <= hcsl_all;
      pair_pecl_q <= pecl_all;
    end
  end
endmodule
`default_nettype wire

// [testbench/oem_regs_sva.sv]
// assertions on the output stage register bank ports
`timescale 1ns/1ps
`default_nettype none
module oem_regs_chk (
  // watched ports
  input wire ref_clk, nrst, cfg_wr, cfg_rd,
  input wire [7:0] cfg_addr, cfg_wdata, cfg_rdata_q, cfg_clock_out_q, cfg_clock_oe_q,
  input wire [3:0] hp_single_ended_out_q, hp_single_ended_enable_bits_q, pair_hcsl_q, pair_pecl_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire [7:0] d = cfg_wdata, e = cfg_clock_oe_q, o = cfg_clock_out_q;
  wire w1 = cfg_wr && cfg_addr == 8'hb1, w2 = cfg_wr && cfg_addr == 8'hb2;
  wire w3 = cfg_wr && cfg_addr == 8'hb3;
  property p_en; w1 |-> ##2 hp_single_ended_enable_bits_q == $past(d[3:0], 2); endproperty
  a_en: assert property (p_en) else $error("hp enable wrong");
  property p_tri; (hp_single_ended_out_q & ~hp_single_ended_enable_bits_q) == 4'h0; endproperty
  a_tri: assert property (p_tri) else $error("disabled hp output drives");
  property p_off; w2 && d[2:0] == 3'h0 |-> ##2 e[5:4] == 2'b00; endproperty
  a_off: assert property (p_off) else $error("pair not off");
  property p_even; w2 && d[2:0] == 3'h1 |-> ##2 e[5:4] == 2'b01; endproperty
  a_even: assert property (p_even) else $error("single even wrong");
  property p_comp; w3 && d[2:0] == 3'h4 |-> ##2 e[1:0] == 2'b11 && o[1] != o[0]; endproperty
  a_comp: assert property (p_comp) else $error("complementary wrong");
  property p_hcsl; w3 && d[6:4] == 3'h5 |-> ##2 pair_hcsl_q[1] && !pair_pecl_q[1]; endproperty
  a_hcsl: assert property (p_hcsl) else $error("hcsl flag wrong");
  property p_undef; w2 && d[6:4] == 3'h7 |-> ##2 e[7:6] == 2'b00; endproperty
  a_undef: assert property (p_undef) else $error("mode seven drives");
  property p_inv; pair_hcsl_q[2] || pair_pecl_q[2] |-> o[5] == !o[4]; endproperty
  a_inv: assert property (p_inv) else $error("five not inverse of four");
  property p_rsv; cfg_rd && (cfg_addr == 8'hb1 || cfg_addr == 8'hb4) |=> cfg_rdata_q[7:4] == 0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read set");
endmodule
bind oem_regs oem_regs_chk i_oem_regs_chk (.*);
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the output stage register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  reg ref_clk = 0, nrst = 0, cfg_wr = 0, cfg_rd = 0, rv = 0;
  reg synth_three_divider_a = 0, synth_one_divider_c = 0;
  reg synth_three_divider_c = 0, synth_one_divider_d = 0;
  reg [7:0] cfg_addr = 0, cfg_wdata = 0, r;
  reg [3:0] hp_src = 0, low_src = 0;
  reg [1:0] six_seven_src = 0, e;
  reg [3:0] hp_h1 = 0, hp_h2 = 0, hp_h3 = 0;
  reg [2:0] s5_h = 0;
  wire [7:0] cfg_rdata_q, cfg_clock_out_q, cfg_clock_oe_q;
  wire [3:0] hp_single_ended_out_q, hp_single_ended_enable_bits_q, pair_hcsl_q, pair_pecl_q;
  integer seed = 32'h7180ee82, fail_count = 0, n_checks = 0, cyc = 0, i;
  reg [7:0] q[$];
  oem_regs i_oem_regs (.*);
  always #25 ref_clk = ~ref_clk;
  task chk(input [7:0] got, exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d bad %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // a read notes its expected data for the monitor
  task bus(input w, input [7:0] a, d);
    begin
      @(posedge ref_clk);
      cfg_wr <= w;
      cfg_rd <= !w;
      cfg_addr <= a;
      cfg_wdata <= d;
      if (!w) q.push_back(d);
    end
  endtask
  task idle(input integer n);
    begin
      @(posedge ref_clk);
      cfg_wr <= 0;
      cfg_rd <= 0;
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
    end
  endtask
  always @(posedge ref_clk) begin
    rv <= cfg_rd;
    {hp_h3, hp_h2, hp_h1} <= {hp_h2, hp_h1, hp_src};
    s5_h <= {s5_h[1:0], synth_three_divider_c};
    {hp_src, low_src, six_seven_src, synth_three_divider_c, synth_one_divider_d} <= $random(seed);
    cyc <= cyc + 1;
  end
  always @(negedge ref_clk) begin
    if (rv) chk(cfg_rdata_q, q.pop_front());
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1;
    for (i = 0; i < 5; i = i + 1) bus(0, 8'hb1 + i, 8'h00);
    for (i = 0; i < 5; i = i + 1) bus(1, 8'hb1 + i, 8'hff);
    for (i = 0; i < 5; i = i + 1) bus(0, 8'hb1 + i, i == 1 || i == 2 ? 8'h77 : i < 4 ? 8'h0f : 0);
    idle(2);
    $display("register test done");
    for (i = 0; i < 8; i = i + 1) begin
      r = {1'b0, i[2:0], 1'b0, i[2:0]};
      bus(1, 8'hb2, r);
      bus(1, 8'hb3, r);
      idle(2);
      e = i == 1 ? 2'b01 : i == 2 ? 2'b10 : i > 2 && i < 7 ? 2'b11 : 2'b00;
      chk(cfg_clock_oe_q, {4{e}});
      chk(pair_hcsl_q, {4{i == 5}});
      chk(pair_pecl_q, {4{i == 6}});
      if (i > 3 && i < 7) chk(cfg_clock_out_q & 8'haa, ~cfg_clock_out_q << 1 & 8'haa);
    end
    $display("mode test done");
    for (i = 0; i < 8; i = i + 1) begin
      r = $random(seed);
      bus(1, 8'hb1, r);
      idle(2);
      chk(hp_single_ended_enable_bits_q, r[3:0]);
      chk(hp_single_ended_out_q & ~r[3:0], 4'h0);
      chk(hp_single_ended_out_q, hp_h3 & r[3:0]);
    end
    $display("enable test done");
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 8'hb2, i[1] ? 8'h05 : 8'h03);
      synth_three_divider_a <= !i[0];
      synth_one_divider_c <= i[0];
      bus(1, 8'hb4, i[0]); // synth three enable sits outside this bank
      idle(2);
      chk(cfg_clock_out_q[5:4], i[1] ? 2'b01 : {s5_h[2], 1'b1});
    end
    $display("select test done");
    give_verdict;
  end
endmodule
`default_nettype wire
